// ==== src/ssp_pkg.sv ====
// Purpose: shared constants of the serial port and its external master
// Assumes: 125 MHz clk, 8-bit words
// Notes: register indices are addresses on the 3-bit register port
package ssp_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int CLK_PERIOD_NS = 8;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_STAT = 3'h1;
	localparam logic [2:0] REG_BUF = 3'h2;
	localparam logic [2:0] REG_OWN = 3'h3;
	localparam logic [2:0] REG_FLAG = 3'h4;
	localparam int CTRL_OV = 6;
	localparam int CTRL_EN = 5;
	localparam int CTRL_CKP = 4;
	localparam int STAT_SMP = 7;
	localparam int STAT_CKE = 6;
	localparam int STAT_RW = 2;
	localparam int STAT_UA = 1;
	localparam int STAT_BF = 0;
	localparam int FLAG_IF = 3;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [3:0] MODE_SPI_M4 = 4'h0;
	localparam logic [3:0] MODE_SPI_M16 = 4'h1;
	localparam logic [3:0] MODE_SPI_M64 = 4'h2;
	localparam logic [3:0] MODE_SPI_MTMR = 4'h3;
	localparam logic [3:0] MODE_SPI_S_SS = 4'h4;
	localparam logic [3:0] MODE_SPI_S = 4'h5;
	localparam logic [3:0] MODE_I2C_7 = 4'h6;
	localparam logic [3:0] MODE_I2C_10 = 4'h7;
	localparam int FOSC_DIV_A = 4;
	localparam int FOSC_DIV_B = 16;
	localparam int FOSC_DIV_C = 64;
	// terminal counts of the half-period divider
	localparam logic [5:0] HALF_A = 6'(FOSC_DIV_A / 2 - 1);
	localparam logic [5:0] HALF_B = 6'(FOSC_DIV_B / 2 - 1);
	localparam logic [5:0] HALF_C = 6'(FOSC_DIV_C / 2 - 1);
	localparam logic [4:0] SPI_LAST_STEP = 5'h10;
	localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] ACK_BIT = 4'h9;
	localparam logic [4:0] SYNC_RESET = 5'h07;
	localparam logic [2:0] CMD_SPI = 3'h0;
	localparam logic [2:0] CMD_START = 3'h1;
	localparam logic [2:0] CMD_WRITE = 3'h2;
	localparam logic [2:0] CMD_STOP = 3'h3;
endpackage

// ==== src/ssp_if.sv ====
// Purpose: pins between the serial port and an external bus master
// Assumes: sck is driven by the port while its enable is high, else by the external master
// Notes: scl and sda are open drain, resolved here from the enables
`timescale 1ns/10ps
interface ssp_if;
	logic dev_sck;
	logic dev_sck_oe;
	logic ext_sck;
	logic dev_sdo;
	logic ext_sdo;
	logic ss_n;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic ext_scl_o;
	logic ext_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic ext_sda_o;
	logic ext_sda_oe;
	logic sck;
	logic scl;
	logic sda;
	assign sck = dev_sck_oe ? dev_sck : ext_sck;
	assign scl = !(dev_scl_oe || ext_scl_oe);
	assign sda = !(dev_sda_oe || ext_sda_oe);
	modport dev (output dev_sck, dev_sck_oe, dev_sdo, dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
		input sck, ext_sdo, ss_n, scl, sda);
	modport ext (output ext_sck, ext_sdo, ss_n, ext_scl_o, ext_scl_oe, ext_sda_o, ext_sda_oe,
		input sck, dev_sdo, scl, sda);
endinterface

// ==== src/ssp_port.sv ====
// Purpose: synchronous serial port, spi master/slave and i2c slave
// Assumes: register port strobes are one cycle, read data one cycle later
// Notes: i2c slave transmit is not served; a read address is acked then ignored
`timescale 1ns/10ps
// What this block does
// - clock polarity bit sets spi clock idle
// - spi words go out msb first
// - master rate clk/4, /16, /64, timer/2
// - edge select one: data valid before edge
// - master sample point follows sample phase
// - slave shifts on external clock, flags word
// - slave keeps working and flags during sleep
// - slave-select high resets slave with control
// - software enables slave-select when edge select one
// - no ack if full or overflow before
// - full buffer: no copy, set flag, overflow
// - buffer read clears full; overflow by write
// - i2c waits start, samples eight rising edges
// - address bits 7:1 compared on eighth fall
// - match and clear flags: load, full, ack
// - accepted address flags on ninth fall
// - ten-bit header 11110, two bits, write
// - ten-bit byte sets update flag, holds clock
// - software swaps low and high address bytes
// - after restart a read matches only the high byte
// - write address clears read bit, loads buffer
// - every data byte flags; software clears flag
// - overflow without full: buffer updated, no ack
module ssp_port (
	input wire logic clk,
	input wire logic reset,
	ssp_if.dev bus,
	input wire logic [ssp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [ssp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ssp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic timer_tick,
	output logic port_interrupt_flag
);
	typedef enum logic [4:0] {
		I_IDLE = 5'b00001,
		I_ADDR = 5'b00010,
		I_ADDR2 = 5'b00100,
		I_DATA = 5'b01000,
		I_SKIP = 5'b10000
	} ssp_i2c_st_t;

	logic [3:0] mode_r;
	logic en_r, ckp_r, ov_r, smp_r, cke_r, rw_r, ua_r, bf_r, if_r;
	logic [7:0] buffer_register_r, own_address_register_r, tx_r, rdata_r;
	logic [4:0] s1_r, s2_r, s3_r;
	logic is_spim, is_spis, is_i2c, ten, ss_rst;
	logic ctrl_wr, stat_wr, buf_wr, own_wr, flag_wr, buf_rd;
	logic sck_rise, sck_fall, sdi, scl_rise, scl_fall, sda, start_c, stop_c;
	logic spim_busy_r, sck_act_r, tick, m_samp, m_chg, spim_done;
	logic [4:0] h_r;
	logic [5:0] div_r, half_lim;
	logic [7:0] mrx_r, srx_r, spim_fin;
	logic [3:0] scnt_r;
	logic lead, trail, s_samp, s_chg, spis_done;
	ssp_i2c_st_t st_r, i2c_next;
	logic [3:0] bcnt_r;
	logic [7:0] shift_register_r;
	logic ack_r, take_r, ua_pend_r, hi_ok_r, i2c_take, i2c_fall8, i2c_fall9, i2c_load;
	logic rx_done, flag_set;
	logic [7:0] rx_val;

	assign is_spim = en_r && (mode_r <= ssp_pkg::MODE_SPI_MTMR);
	assign is_spis = en_r && (mode_r == ssp_pkg::MODE_SPI_S_SS || mode_r == ssp_pkg::MODE_SPI_S);
	assign is_i2c = en_r && (mode_r == ssp_pkg::MODE_I2C_7 || mode_r == ssp_pkg::MODE_I2C_10);
	assign ten = mode_r == ssp_pkg::MODE_I2C_10;
	assign ctrl_wr = reg_wr && reg_addr == ssp_pkg::REG_CTRL;
	assign stat_wr = reg_wr && reg_addr == ssp_pkg::REG_STAT;
	assign buf_wr = reg_wr && reg_addr == ssp_pkg::REG_BUF;
	assign own_wr = reg_wr && reg_addr == ssp_pkg::REG_OWN;
	assign flag_wr = reg_wr && reg_addr == ssp_pkg::REG_FLAG;
	assign buf_rd = reg_rd && reg_addr == ssp_pkg::REG_BUF;

	// order {sck, sdi, ss_n, scl, sda}; stage 1 feeds stage 2 only
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_r <= ssp_pkg::SYNC_RESET;
			s2_r <= ssp_pkg::SYNC_RESET;
			s3_r <= ssp_pkg::SYNC_RESET;
		end else begin
			s1_r <= {bus.sck, bus.ext_sdo, bus.ss_n, bus.scl, bus.sda};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign sck_rise = s2_r[4] && !s3_r[4];
	assign sck_fall = !s2_r[4] && s3_r[4];
	assign sdi = s2_r[3];
	assign ss_rst = mode_r == ssp_pkg::MODE_SPI_S_SS && s2_r[2];
	assign scl_rise = s2_r[1] && !s3_r[1];
	assign scl_fall = !s2_r[1] && s3_r[1];
	assign sda = s2_r[0];
	assign start_c = s2_r[1] && s3_r[1] && s3_r[0] && !s2_r[0];
	assign stop_c = s2_r[1] && s3_r[1] && !s3_r[0] && s2_r[0];

	// spi master bit clock
	always_comb begin
		unique case (mode_r)
			ssp_pkg::MODE_SPI_M4: half_lim = ssp_pkg::HALF_A;
			ssp_pkg::MODE_SPI_M16: half_lim = ssp_pkg::HALF_B;
			default: half_lim = ssp_pkg::HALF_C;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset || !spim_busy_r || div_r == half_lim)
			div_r <= 6'h00;
		else
			div_r <= div_r + 6'h01;
	end
	// timer mode toggles once per timer pulse, so the bit clock is half the timer rate
	assign tick = spim_busy_r && (mode_r == ssp_pkg::MODE_SPI_MTMR ? timer_tick : div_r == half_lim);
	// even steps are leading edges; a late sample on cke 0 lands on the extra step 16
	assign m_samp = (h_r[0] == (cke_r ~^ smp_r))
		&& ((!cke_r && smp_r) ? h_r != 5'h00 : h_r != ssp_pkg::SPI_LAST_STEP);
	assign m_chg = cke_r ? (h_r[0] && h_r < 5'h0f) : (!h_r[0] && h_r != 5'h00 && h_r != ssp_pkg::SPI_LAST_STEP);
	assign spim_fin = m_samp ? {mrx_r[6:0], sdi} : mrx_r;
	assign spim_done = is_spim && tick && h_r == ssp_pkg::SPI_LAST_STEP;
	always_ff @(posedge clk) begin
		if (reset || !is_spim) begin
			spim_busy_r <= 1'b0;
			h_r <= 5'h00;
			sck_act_r <= 1'b0;
			mrx_r <= ssp_pkg::BYTE_RESET;
		end else if (!spim_busy_r) begin
			if (buf_wr) begin
				spim_busy_r <= 1'b1;
				h_r <= 5'h00;
			end
		end else if (tick) begin
			if (h_r != ssp_pkg::SPI_LAST_STEP)
				sck_act_r <= !sck_act_r;
			else
				spim_busy_r <= 1'b0;
			if (m_samp)
				mrx_r <= {mrx_r[6:0], sdi};
			h_r <= h_r + 5'h01;
		end
	end

	// spi slave; with cke 1 the first bit relies on slave-select framing
	assign lead = ckp_r ? sck_fall : sck_rise;
	assign trail = ckp_r ? sck_rise : sck_fall;
	assign s_samp = is_spis && !ss_rst && (cke_r ? lead : trail);
	assign s_chg = is_spis && !ss_rst && (cke_r ? trail : lead) && scnt_r != 4'h0;
	assign spis_done = s_samp && scnt_r == 4'h7;
	always_ff @(posedge clk) begin
		if (reset || !is_spis || ss_rst) begin
			scnt_r <= 4'h0;
			srx_r <= ssp_pkg::BYTE_RESET;
		end else if (s_samp) begin
			srx_r <= {srx_r[6:0], sdi};
			scnt_r <= spis_done ? 4'h0 : scnt_r + 4'h1;
		end
	end

	// transmit shift register shared by both spi roles
	always_ff @(posedge clk) begin
		if (reset)
			tx_r <= ssp_pkg::BYTE_RESET;
		else if (buf_wr && (is_spis || (is_spim && !spim_busy_r)))
			tx_r <= reg_wdata;
		else if ((tick && m_chg) || s_chg)
			tx_r <= {tx_r[6:0], 1'b0};
	end
	assign bus.dev_sdo = tx_r[7];
	assign bus.dev_sck = ckp_r ^ sck_act_r;
	assign bus.dev_sck_oe = is_spim;

	// i2c slave
	always_comb begin
		i2c_take = 1'b0;
		i2c_next = I_SKIP;
		unique case (st_r)
			I_ADDR: begin
				if (shift_register_r[7:1] == own_address_register_r[7:1]
					&& (!ten || shift_register_r[7:3] == ssp_pkg::TEN_BIT_HDR)) begin
					if (!ten) begin
						i2c_take = 1'b1;
						i2c_next = shift_register_r[0] ? I_SKIP : I_DATA;
					end else if (!shift_register_r[0]) begin
						i2c_take = 1'b1;
						i2c_next = I_ADDR2;
					end else if (hi_ok_r) begin
						i2c_take = 1'b1;
					end
				end
			end
			I_ADDR2: begin
				if (shift_register_r == own_address_register_r) begin
					i2c_take = 1'b1;
					i2c_next = I_DATA;
				end
			end
			I_DATA: begin
				i2c_take = 1'b1;
				i2c_next = I_DATA;
			end
			I_IDLE: i2c_next = I_IDLE;
			I_SKIP: i2c_next = I_SKIP;
		endcase
	end
	assign i2c_fall8 = is_i2c && st_r != I_IDLE && !start_c && !stop_c && scl_fall && bcnt_r == ssp_pkg::BYTE_BITS;
	assign i2c_fall9 = is_i2c && st_r != I_IDLE && !start_c && !stop_c && scl_fall && bcnt_r == ssp_pkg::ACK_BIT;
	assign i2c_load = i2c_fall8 && i2c_take;
	always_ff @(posedge clk) begin
		if (reset || !is_i2c) begin
			st_r <= I_IDLE;
			bcnt_r <= 4'h0;
			shift_register_r <= ssp_pkg::BYTE_RESET;
			ack_r <= 1'b0;
			take_r <= 1'b0;
			ua_pend_r <= 1'b0;
			hi_ok_r <= 1'b0;
		end else if (start_c) begin
			st_r <= I_ADDR;
			bcnt_r <= 4'h0;
			ack_r <= 1'b0;
			take_r <= 1'b0;
			ua_pend_r <= 1'b0;
		end else if (stop_c) begin
			st_r <= I_IDLE;
			ack_r <= 1'b0;
			take_r <= 1'b0;
			ua_pend_r <= 1'b0;
			hi_ok_r <= 1'b0;
		end else if (st_r != I_IDLE) begin
			if (scl_rise && bcnt_r != ssp_pkg::ACK_BIT) begin
				if (bcnt_r != ssp_pkg::BYTE_BITS)
					shift_register_r <= {shift_register_r[6:0], sda};
				bcnt_r <= bcnt_r + 4'h1;
			end
			if (i2c_fall8) begin
				ack_r <= i2c_take && !bf_r && !ov_r;
				take_r <= i2c_take;
				ua_pend_r <= i2c_take && ten && (st_r == I_ADDR2 || (st_r == I_ADDR && !shift_register_r[0]));
				if (st_r == I_ADDR2 && i2c_take)
					hi_ok_r <= 1'b1;
				st_r <= i2c_next;
			end
			if (i2c_fall9) begin
				ack_r <= 1'b0;
				take_r <= 1'b0;
				ua_pend_r <= 1'b0;
				bcnt_r <= 4'h0;
			end
		end
	end
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = ack_r;
	assign bus.dev_scl_o = 1'b0;
	// clock held low after the ninth fall until the own address is rewritten
	assign bus.dev_scl_oe = is_i2c && ua_r;

	// buffer and flags; hardware sets win over software clears
	assign rx_done = spim_done || spis_done || i2c_load;
	assign rx_val = spim_done ? spim_fin : (spis_done ? {srx_r[6:0], sdi} : shift_register_r);
	// no processor clock gating here, so slave transfers and flags go on in sleep
	assign flag_set = spim_done || spis_done || (i2c_fall9 && take_r);
	always_ff @(posedge clk) begin
		if (reset) begin
			buffer_register_r <= ssp_pkg::BYTE_RESET;
			bf_r <= 1'b0;
		end else if (rx_done && !bf_r) begin
			buffer_register_r <= rx_val;
			bf_r <= 1'b1;
		end else if (buf_rd) begin
			bf_r <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_r <= 4'h0;
			en_r <= 1'b0;
			ckp_r <= 1'b0;
			ov_r <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				mode_r <= reg_wdata[3:0];
				en_r <= reg_wdata[ssp_pkg::CTRL_EN];
				ckp_r <= reg_wdata[ssp_pkg::CTRL_CKP];
			end
			if (rx_done && bf_r)
				ov_r <= 1'b1;
			else if (ctrl_wr)
				ov_r <= reg_wdata[ssp_pkg::CTRL_OV];
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			smp_r <= 1'b0;
			cke_r <= 1'b0;
		end else if (stat_wr) begin
			smp_r <= reg_wdata[ssp_pkg::STAT_SMP];
			cke_r <= reg_wdata[ssp_pkg::STAT_CKE];
		end
	end
	always_ff @(posedge clk) begin
		if (reset)
			rw_r <= 1'b0;
		else if (i2c_load && st_r == I_ADDR)
			rw_r <= shift_register_r[0];
	end
	always_ff @(posedge clk) begin
		if (reset)
			ua_r <= 1'b0;
		else if (i2c_fall9 && ua_pend_r)
			ua_r <= 1'b1;
		else if (own_wr)
			ua_r <= 1'b0;
	end
	always_ff @(posedge clk) begin
		if (reset)
			own_address_register_r <= ssp_pkg::BYTE_RESET;
		else if (own_wr)
			own_address_register_r <= reg_wdata;
	end
	always_ff @(posedge clk) begin
		if (reset)
			if_r <= 1'b0;
		else if (flag_set)
			if_r <= 1'b1;
		else if (flag_wr)
			if_r <= reg_wdata[ssp_pkg::FLAG_IF];
	end
	assign port_interrupt_flag = if_r;

	always_ff @(posedge clk) begin
		if (reset || !reg_rd) begin
			rdata_r <= ssp_pkg::BYTE_RESET;
		end else begin
			unique case (reg_addr)
				ssp_pkg::REG_CTRL: rdata_r <= {1'b0, ov_r, en_r, ckp_r, mode_r};
				ssp_pkg::REG_STAT: rdata_r <= {smp_r, cke_r, 3'h0, rw_r, ua_r, bf_r};
				ssp_pkg::REG_BUF: rdata_r <= buffer_register_r;
				ssp_pkg::REG_OWN: rdata_r <= own_address_register_r;
				ssp_pkg::REG_FLAG: rdata_r <= {4'h0, if_r, 3'h0};
				default: rdata_r <= ssp_pkg::BYTE_RESET;
			endcase
		end
	end
	assign reg_rdata = rdata_r;
endmodule

// ==== src/ssp_ext.sv ====
// Purpose: external spi master and i2c master facing the serial port
// Assumes: one command at a time; i2c bus idle high at first start
// Notes: i2c commands are start, write byte with ack check, and stop
`timescale 1ns/10ps
module ssp_ext #(
	parameter int HALF = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cmd_valid,
	input wire logic [2:0] cmd,
	input wire logic [7:0] cmd_data,
	input wire logic spi_cpol,
	input wire logic spi_cke,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	ssp_if.ext bus
);
	typedef enum logic [4:0] {
		X_IDLE = 5'b00001,
		X_SPI = 5'b00010,
		X_START = 5'b00100,
		X_WRITE = 5'b01000,
		X_STOP = 5'b10000
	} ssp_ext_st_t;

	// the port samples through two flops, so a half bit needs several clocks
	if (HALF < 4) begin : g_half_check
		$error("HALF must be at least 4");
	end

	ssp_ext_st_t st_r;
	logic [15:0] div_r;
	logic [5:0] step_r;
	logic [7:0] sh_r, rx_r, rsp_data_r;
	logic sck_r, cpol_r, cke_r, ss_n_r, scl_oe_r, sda_oe_r, nack_r, rsp_valid_r;
	logic tick, stretch, lead, samp, chg;
	logic [4:0] e;

	assign cmd_ready = st_r == X_IDLE;
	// a released clock still held low by the port freezes the divider
	assign stretch = !scl_oe_r && !bus.scl;
	assign tick = st_r != X_IDLE && !stretch && div_r == 16'(HALF - 1);
	always_ff @(posedge clk) begin
		if (reset || st_r == X_IDLE || tick || stretch)
			div_r <= 16'h0000;
		else
			div_r <= div_r + 16'h0001;
	end

	assign e = 5'(step_r - 6'h01);
	assign lead = !e[0];
	assign samp = step_r != 6'h00 && step_r <= 6'h10 && (cke_r ? lead : !lead);
	assign chg = step_r != 6'h00 && step_r <= 6'h10 && (cke_r ? (!lead && e < 5'h0f) : (lead && e != 5'h00));

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= X_IDLE;
			step_r <= 6'h00;
			sh_r <= 8'h00;
			rx_r <= 8'h00;
			sck_r <= 1'b0;
			cpol_r <= 1'b0;
			cke_r <= 1'b0;
			ss_n_r <= 1'b1;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			nack_r <= 1'b0;
			rsp_valid_r <= 1'b0;
			rsp_data_r <= 8'h00;
		end else begin
			rsp_valid_r <= 1'b0;
			if (st_r == X_IDLE) begin
				if (cmd_valid) begin
					step_r <= 6'h00;
					sh_r <= cmd_data;
					cpol_r <= spi_cpol;
					cke_r <= spi_cke;
					sck_r <= 1'b0;
					unique case (cmd)
						ssp_pkg::CMD_SPI: st_r <= X_SPI;
						ssp_pkg::CMD_START: st_r <= X_START;
						ssp_pkg::CMD_WRITE: st_r <= X_WRITE;
						default: st_r <= X_STOP;
					endcase
				end
			end else if (tick) begin
				step_r <= step_r + 6'h01;
				unique case (st_r)
					X_SPI: begin
						if (step_r == 6'h00)
							ss_n_r <= 1'b0;
						if (step_r != 6'h00 && step_r <= 6'h10)
							sck_r <= !sck_r;
						if (samp)
							rx_r <= {rx_r[6:0], bus.dev_sdo};
						if (chg)
							sh_r <= {sh_r[6:0], 1'b0};
						if (step_r == 6'h11) begin
							ss_n_r <= 1'b1;
							rsp_data_r <= rx_r;
							rsp_valid_r <= 1'b1;
							st_r <= X_IDLE;
						end
					end
					X_START: begin
						unique case (step_r[1:0])
							2'h0: sda_oe_r <= 1'b0;
							2'h1: scl_oe_r <= 1'b0;
							2'h2: sda_oe_r <= 1'b1;
							2'h3: begin
								scl_oe_r <= 1'b1;
								rsp_valid_r <= 1'b1;
								st_r <= X_IDLE;
							end
						endcase
					end
					X_WRITE: begin
						unique case (step_r[1:0])
							2'h0: sda_oe_r <= step_r[5:2] != 4'h8 && !sh_r[7];
							2'h1: scl_oe_r <= 1'b0;
							2'h2: if (step_r[5:2] == 4'h8) nack_r <= bus.sda;
							2'h3: begin
								scl_oe_r <= 1'b1;
								sh_r <= {sh_r[6:0], 1'b0};
								if (step_r[5:2] == 4'h8) begin
									rsp_valid_r <= 1'b1;
									st_r <= X_IDLE;
								end
							end
						endcase
					end
					X_STOP: begin
						if (step_r == 6'h00)
							sda_oe_r <= 1'b1;
						else if (step_r == 6'h01)
							scl_oe_r <= 1'b0;
						else begin
							sda_oe_r <= 1'b0;
							rsp_valid_r <= 1'b1;
							st_r <= X_IDLE;
						end
					end
					X_IDLE: st_r <= X_IDLE;
				endcase
			end
		end
	end
	assign bus.ext_sck = cpol_r ^ sck_r;
	assign bus.ext_sdo = sh_r[7];
	assign bus.ss_n = ss_n_r;
	assign bus.ext_scl_o = 1'b0;
	assign bus.ext_scl_oe = scl_oe_r;
	assign bus.ext_sda_o = 1'b0;
	assign bus.ext_sda_oe = sda_oe_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp_data = rsp_data_r;
	assign rsp_nack = nack_r;
endmodule

// ==== testbench/ssp_properties.sv ====
// Purpose: pin level timing checks between the serial port and its external master
// Assumes: both ends are design code joined by one interface, one clock
// Notes: counts assume the external master runs at half bit of 8 clocks
`timescale 1ns/10ps
module ssp_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic sck,
	input wire logic scl,
	input wire logic ss_n,
	input wire logic dev_sck,
	input wire logic dev_sck_oe,
	input wire logic dev_sdo,
	input wire logic dev_sda_oe,
	input wire logic dev_scl_oe
);
	logic sck_r;
	logic [4:0] tog_r;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// edges seen while selected; one word is sixteen
	always_ff @(posedge clk) begin
		sck_r <= sck;
		if (reset || ss_n) begin
			tog_r <= 5'h00;
		end else if (sck != sck_r) begin
			tog_r <= tog_r + 5'h01;
		end
	end
	AST_SCK_LEAD: assert property ($fell(ss_n) |-> $stable(sck)[*4])
		else $error("serial clock moved right after select");
	AST_SDO_LEAD: assert property ($fell(ss_n) |-> $stable(dev_sdo)[*4])
		else $error("serial out not settled before first edge");
	AST_WORD_EDGES: assert property ($rose(ss_n) |-> tog_r == 5'h10)
		else $error("word not sixteen clock edges");
	AST_MASTER_HALF: assert property (dev_sck_oe && $changed(dev_sck) |=> $stable(dev_sck))
		else $error("master half period below two clocks");
	AST_ACK_START: assert property ($rose(dev_sda_oe) |-> !scl)
		else $error("ack started with clock high");
	AST_ACK_HOLD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe[*8])
		else $error("ack pulse too short");
	AST_ACK_STEADY: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("data line moved while clock high");
	AST_ACK_END: assert property ($fell(dev_sda_oe) |-> !scl)
		else $error("ack released with clock high");
	AST_STRETCH: assert property ($rose(dev_scl_oe) |-> !$past(scl))
		else $error("clock hold began while clock high");
endmodule

// ==== testbench/test_sync_serial_spi_i2c_slave_port.sv ====
// Purpose: self-checking bench of the serial port against its external master
// Assumes: external master at half bit of 8 clocks, timer tick every 5 clocks
// Notes: spi slave rows and master rates run in loops; i2c cases follow by hand
`timescale 1ns/10ps
module test_sync_serial_spi_i2c_slave_port;
	typedef struct packed {logic [3:0] mode; logic clock_polarity_select; logic cke; logic [7:0] dv; logic [7:0] ev;} ssp_row_t;
	// edge select set only with select control
	localparam ssp_row_t ROWS [4] = '{'{4'h5, 1'h0, 1'h0, 8'h96, 8'h3c}, '{4'h4, 1'h1, 1'h1, 8'h81, 8'h7e},
		'{4'h4, 1'h0, 1'h1, 8'h01, 8'hc5}, '{4'h5, 1'h0, 1'h0, 8'he8, 8'h5a}};
	localparam int HALVES [4] = '{ssp_pkg::FOSC_DIV_A / 2, ssp_pkg::FOSC_DIV_B / 2, ssp_pkg::FOSC_DIV_C / 2, 5};
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic timer_tick = 1'h0;
	logic [2:0] tcnt = 3'h0;
	logic pif;
	logic cmd_valid = 1'h0;
	logic [2:0] cmd = 3'h0;
	logic [7:0] cmd_data = 8'h00;
	logic spi_cpol = 1'h0;
	logic spi_cke = 1'h0;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_nack;
	logic s;
	int n;
	int error_cnt = 0;
	int n_checks = 0;
	ssp_if ssp_if_i ();
	ssp_port ssp_port_i (.clk(clk), .reset(reset), .bus(ssp_if_i), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_tick(timer_tick), .port_interrupt_flag(pif));
	ssp_ext #(.HALF(8)) ssp_ext_i (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_data(cmd_data),
		.spi_cpol(spi_cpol), .spi_cke(spi_cke), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .bus(ssp_if_i));
	ssp_checker ssp_checker_i (.clk(clk), .reset(reset), .sck(ssp_if_i.sck), .scl(ssp_if_i.scl), .ss_n(ssp_if_i.ss_n),
		.dev_sck(ssp_if_i.dev_sck), .dev_sck_oe(ssp_if_i.dev_sck_oe), .dev_sdo(ssp_if_i.dev_sdo),
		.dev_sda_oe(ssp_if_i.dev_sda_oe), .dev_scl_oe(ssp_if_i.dev_scl_oe));
	always #(ssp_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
	always @(posedge clk) begin
		tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
		timer_tick <= (tcnt == 3'h4);
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, want);
		end
	endtask
	task automatic bit1(input logic seen, input logic want);
		chk({7'h00, seen}, {7'h00, want});
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] want);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata & m, want);
	endtask
	// sel 0 waits for the master's answer, 1 for the port's flag
	task automatic waitfor(input logic sel);
		for (int i = 0; i < 20000; i++) begin
			@(posedge clk);
			#1;
			if ((sel ? pif : rsp_valid) === 1'h1)
				return;
		end
		error_cnt++;
		$display("unexpected at %0t: wait ran out", $time);
		final_report();
	endtask
	task automatic issue(input logic [2:0] c, input logic [7:0] d);
		@(posedge clk);
		cmd_valid <= 1'h1;
		cmd <= c;
		cmd_data <= d;
		@(posedge clk);
		cmd_valid <= 1'h0;
	endtask
	task automatic xfer(input logic [2:0] c, input logic [7:0] d);
		issue(c, d);
		waitfor(1'h0);
		// port sees the pins through its synchroniser, so its i2c flags trail the answer
		repeat (4) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'h0;
		rd(ssp_pkg::REG_CTRL, 8'hff, 8'h00);
		rd(ssp_pkg::REG_STAT, 8'hff, 8'h00);
		chk({5'h00, pif, ssp_if_i.scl, ssp_if_i.sda}, 8'h03);
		$display("reset test done");
		foreach (ROWS[k]) begin
			wr(ssp_pkg::REG_CTRL, {3'h1, ROWS[k].clock_polarity_select, ROWS[k].mode});
			wr(ssp_pkg::REG_STAT, {1'h0, ROWS[k].cke, 6'h00});
			wr(ssp_pkg::REG_BUF, ROWS[k].dv);
			spi_cpol <= ROWS[k].clock_polarity_select;
			spi_cke <= ROWS[k].cke;
			xfer(ssp_pkg::CMD_SPI, ROWS[k].ev);
			chk(rsp_data, ROWS[k].dv);
			bit1(pif, 1'h1);
			rd(ssp_pkg::REG_BUF, 8'hff, ROWS[k].ev);
			rd(ssp_pkg::REG_STAT, 8'h01, 8'h00);
			wr(ssp_pkg::REG_FLAG, 8'h00);
			$display("spi slave row %0d done", k);
		end
		// second byte lands on a full buffer; its last bit leaves the master's data line high
		xfer(ssp_pkg::CMD_SPI, 8'h11);
		xfer(ssp_pkg::CMD_SPI, 8'h23);
		rd(ssp_pkg::REG_BUF, 8'hff, 8'h11);
		rd(ssp_pkg::REG_CTRL, 8'h40, 8'h40);
		wr(ssp_pkg::REG_CTRL, 8'h25);
		rd(ssp_pkg::REG_CTRL, 8'h40, 8'h00);
		wr(ssp_pkg::REG_FLAG, 8'h00);
		$display("spi overflow test done");
		for (int m = 0; m < 4; m++) begin
			wr(ssp_pkg::REG_CTRL, {3'h1, m[0], 4'(m)});
			#1;
			bit1(ssp_if_i.sck, m[0]);
			wr(ssp_pkg::REG_BUF, 8'h5a);
			#1;
			for (int e = 0; e < 2; e++) begin
				s = ssp_if_i.sck;
				n = 0;
				while (ssp_if_i.sck === s && n < 300) begin
					@(posedge clk);
					#1;
					n++;
				end
			end
			chk(8'(n), 8'(HALVES[m]));
			waitfor(1'h1);
			rd(ssp_pkg::REG_BUF, 8'hff, 8'hff);
			wr(ssp_pkg::REG_FLAG, 8'h00);
			$display("spi master rate %0d done", m);
		end
		wr(ssp_pkg::REG_OWN, 8'h52);
		wr(ssp_pkg::REG_CTRL, {4'h2, ssp_pkg::MODE_I2C_7});
		xfer(ssp_pkg::CMD_START, 8'h00);
		xfer(ssp_pkg::CMD_WRITE, 8'h52);
		bit1(rsp_nack, 1'h0);
		bit1(pif, 1'h1);
		rd(ssp_pkg::REG_STAT, 8'h05, 8'h01);
		rd(ssp_pkg::REG_BUF, 8'hff, 8'h52);
		wr(ssp_pkg::REG_FLAG, 8'h00);
		xfer(ssp_pkg::CMD_WRITE, 8'ha5);
		bit1(rsp_nack, 1'h0);
		bit1(pif, 1'h1);
		wr(ssp_pkg::REG_FLAG, 8'h00);
		xfer(ssp_pkg::CMD_WRITE, 8'h3c);
		bit1(rsp_nack, 1'h1);
		bit1(pif, 1'h1);
		rd(ssp_pkg::REG_CTRL, 8'h40, 8'h40);
		rd(ssp_pkg::REG_BUF, 8'hff, 8'ha5);
		xfer(ssp_pkg::CMD_WRITE, 8'h77);
		bit1(rsp_nack, 1'h1);
		rd(ssp_pkg::REG_BUF, 8'hff, 8'h77);
		xfer(ssp_pkg::CMD_STOP, 8'h00);
		wr(ssp_pkg::REG_CTRL, {4'h2, ssp_pkg::MODE_I2C_7});
		wr(ssp_pkg::REG_FLAG, 8'h00);
		xfer(ssp_pkg::CMD_START, 8'h00);
		xfer(ssp_pkg::CMD_WRITE, 8'h54);
		bit1(rsp_nack, 1'h1);
		bit1(pif, 1'h0);
		xfer(ssp_pkg::CMD_STOP, 8'h00);
		$display("i2c seven-bit test done");
		wr(ssp_pkg::REG_OWN, 8'hf2);
		wr(ssp_pkg::REG_CTRL, {4'h2, ssp_pkg::MODE_I2C_10});
		xfer(ssp_pkg::CMD_START, 8'h00);
		for (int j = 0; j < 2; j++) begin
			xfer(ssp_pkg::CMD_WRITE, j ? 8'h34 : 8'hf2);
			bit1(rsp_nack, 1'h0);
			waitfor(1'h1);
			rd(ssp_pkg::REG_BUF, 8'hff, j ? 8'h34 : 8'hf2);
			wr(ssp_pkg::REG_FLAG, 8'h00);
			rd(ssp_pkg::REG_STAT, 8'h02, 8'h02);
			bit1(ssp_if_i.dev_scl_oe, 1'h1);
			wr(ssp_pkg::REG_OWN, j ? 8'hf2 : 8'h34);
			rd(ssp_pkg::REG_STAT, 8'h02, 8'h00);
			bit1(ssp_if_i.dev_scl_oe, 1'h0);
		end
		xfer(ssp_pkg::CMD_START, 8'h00);
		xfer(ssp_pkg::CMD_WRITE, 8'hf3);
		bit1(rsp_nack, 1'h0);
		rd(ssp_pkg::REG_STAT, 8'h02, 8'h00);
		xfer(ssp_pkg::CMD_STOP, 8'h00);
		$display("i2c ten-bit test done");
		final_report();
	end
endmodule
